// file: swcd_serial_wiper_command_decoder.sv
// Command decoder and register logic of a 256-tap serially controlled potentiometer.
// Assumes a bit engine outside that raises frameActive from start to stop, in the
// serial clock domain; the data pin is stable around rising serial clock edges.
`timescale 1ns/1ps

module swcd_serial_wiper_command_decoder
    import swcd_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
    // Core clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Serial link, clocked by the master's serial clock.
    input  wire logic         sclClk,
    input  wire logic         frameActive,
    input  wire logic         sdaIn,
    output logic              sdaOut,
    output logic              sdaOeN,
    // Strapped device address pins.
    input  wire logic [2:0]   addressPins,
    // Wiper and status.
    output logic [255:0]      tapSelect,
    output logic [7:0]        wiperPosition,
    output logic              nvBusy
);

    // Link-side frame state; cleared whenever no frame is open.
    logic                linkRst;
    logic [3:0]          bitCount;
    logic [6:0]          shiftIn;
    logic [7:0]          byteNow;
    swcd_phase_t         phase;
    swcd_phase_t         afterPhase;
    logic                ackNow;
    logic [3:0]          curOp;
    logic [3:0]          curPtr;
    logic                isRead;
    // Link-side synchronisers and crossing registers.
    logic [2:0]          addrMeta;
    logic [2:0]          addrSync;
    logic                busyMeta;
    logic                busySync;
    logic                cmdToggle;
    logic [3:0]          cmdOp;
    logic [3:0]          cmdPtr;
    logic [7:0]          cmdData;
    logic                readToggle;
    logic                reqWiper;
    logic [3:0]          reqPtr;
    logic                stepToggle;
    logic                stepUp;
    // Core-side crossing registers.
    logic [2:0]          cmdSync;
    logic [2:0]          readSync;
    logic [2:0]          stepSync;
    logic                cmdEvent;
    logic                readEvent;
    logic                stepEvent;
    logic [7:0]          readData;
    // Core-side storage and timers.
    // Nonvolatile contents start erased to the reset position, so the first recall is defined.
    logic [7:0]          settings [SWCD_SETTING_NUM] = '{default: SWCD_WIPER_RESET};
    logic [7:0]          wiper;
    logic                loadPending;
    logic [23:0]         nvCount;
    logic [3:0]          nvSlot;
    logic [7:0]          nvData;
    logic [7:0]          tapDelay;
    logic                nvStart;

    // Address byte decode; used for both the acknowledge and the next phase.
    function automatic logic swcdAddrMatch(input logic [7:0] b, input logic [2:0] straps);
        return (b[7:4] == SWCD_ID_CODE) && (b[3] == SWCD_ADDR_FILL) && (b[2:0] == straps);
    endfunction : swcdAddrMatch

    // Opcodes that answer with a data byte from the device.
    function automatic logic swcdIsReadOp(input logic [3:0] op);
        return (op == OP_READ_WIPER) || (op == OP_READ_SET);
    endfunction : swcdIsReadOp

    // The link logic is held reset outside frames, so each frame starts at the address byte.
    assign linkRst = rst | ~frameActive;
    assign byteNow = {shiftIn, sdaIn};

    // Straps and the busy level reach the link domain through two flip-flops each.
    always_ff @(posedge sclClk or posedge rst) begin
        if (rst) begin
            addrMeta <= 3'h0;
            addrSync <= 3'h0;
            busyMeta <= 1'b0;
            busySync <= 1'b0;
        end else begin
            addrMeta <= addressPins;
            addrSync <= addrMeta;
            busyMeta <= nvBusy;
            busySync <= busyMeta;
        end
    end

    // Byte framing, acknowledge decisions and phase sequencing on the link.
    always_ff @(posedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            bitCount   <= 4'h0;
            shiftIn    <= 7'h00;
            phase      <= PH_ADDR;
            afterPhase <= PH_IGNORE;
            ackNow     <= 1'b0;
            curOp      <= 4'h0;
            curPtr     <= 4'h0;
            isRead     <= 1'b0;
        end else begin
            shiftIn <= byteNow[6:0];
            if (phase == PH_STEP) begin
                bitCount <= 4'h0;
            end else if (bitCount == SWCD_ACK_SLOT) begin
                bitCount <= 4'h0;
                ackNow   <= 1'b0;
                phase    <= afterPhase;
            end else begin
                bitCount <= bitCount + 4'h1;
                if (bitCount == SWCD_LAST_BIT) begin
                    unique case (phase)
                        PH_ADDR: begin
                            ackNow     <= swcdAddrMatch(byteNow, addrSync) && !busySync;
                            afterPhase <= (swcdAddrMatch(byteNow, addrSync) && !busySync)
                                          ? PH_INSTR : PH_IGNORE;
                        end
                        PH_INSTR: begin
                            ackNow <= swcdInstrValid(byteNow);
                            curOp  <= byteNow[7:4];
                            curPtr <= byteNow[3:0];
                            isRead <= swcdIsReadOp(byteNow[7:4]);
                            if (!swcdInstrValid(byteNow)) begin
                                afterPhase <= PH_IGNORE;
                            end else if (byteNow[7:4] == OP_STEP) begin
                                afterPhase <= PH_STEP;
                            end else if ((byteNow[7:4] == OP_XFR_TO_WIPER) ||
                                         (byteNow[7:4] == OP_XFR_TO_SET)) begin
                                afterPhase <= PH_IGNORE;
                            end else begin
                                afterPhase <= PH_DATA;
                            end
                        end
                        PH_DATA: begin
                            ackNow     <= !isRead;
                            afterPhase <= PH_IGNORE;
                        end
                        PH_STEP, PH_IGNORE: begin
                            ackNow     <= 1'b0;
                            afterPhase <= PH_IGNORE;
                        end
                        default: begin
                            ackNow     <= 1'b0;
                            afterPhase <= PH_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    // Command, read request and step events leave the link as toggles with held fields.
    // The held fields stay unchanged until the next event, long after the core has read them,
    // so only the toggle itself needs the synchroniser.
    always_ff @(posedge sclClk or posedge rst) begin
        if (rst) begin
            cmdToggle  <= 1'b0;
            cmdOp      <= 4'h0;
            cmdPtr     <= 4'h0;
            cmdData    <= 8'h00;
            readToggle <= 1'b0;
            reqWiper   <= 1'b0;
            reqPtr     <= 4'h0;
            stepToggle <= 1'b0;
            stepUp     <= 1'b0;
        end else if (frameActive) begin
            if ((phase == PH_INSTR) && (bitCount == SWCD_LAST_BIT) &&
                swcdInstrValid(byteNow)) begin
                if (swcdIsReadOp(byteNow[7:4])) begin
                    readToggle <= ~readToggle;
                    reqWiper   <= (byteNow[7:4] == OP_READ_WIPER);
                    reqPtr     <= byteNow[3:0];
                end
                if ((byteNow[7:4] == OP_XFR_TO_WIPER) || (byteNow[7:4] == OP_XFR_TO_SET)) begin
                    cmdToggle <= ~cmdToggle;
                    cmdOp     <= byteNow[7:4];
                    cmdPtr    <= byteNow[3:0];
                end
            end
            if ((phase == PH_DATA) && (bitCount == SWCD_LAST_BIT) && !isRead) begin
                cmdToggle <= ~cmdToggle;
                cmdOp     <= curOp;
                cmdPtr    <= curPtr;
                cmdData   <= byteNow;
            end
            if (phase == PH_STEP) begin
                stepToggle <= ~stepToggle;
                stepUp     <= sdaIn;
            end
        end
    end

    // Data pin driven on falling edges: acknowledge slot, then read data bits.
    always_ff @(negedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            sdaOeN <= 1'b1;
        end else if ((bitCount == SWCD_ACK_SLOT) && ackNow) begin
            sdaOeN <= 1'b0;
        end else if ((phase == PH_DATA) && isRead && (bitCount < SWCD_ACK_SLOT)) begin
            sdaOeN <= readData[3'(SWCD_LAST_BIT - bitCount)];
        end else begin
            sdaOeN <= 1'b1;
        end
    end

    // The data pin is open drain; only its low level is ever driven.
    // A fixed register keeps this output straight from a flip-flop like the others.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    // Toggle synchronisers into the core domain; the third stage gives the edge.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmdSync  <= 3'h0;
            readSync <= 3'h0;
            stepSync <= 3'h0;
        end else begin
            cmdSync  <= {cmdSync[1:0], cmdToggle};
            readSync <= {readSync[1:0], readToggle};
            stepSync <= {stepSync[1:0], stepToggle};
        end
    end

    assign cmdEvent  = cmdSync[2] ^ cmdSync[1];
    assign readEvent = readSync[2] ^ readSync[1];
    assign stepEvent = stepSync[2] ^ stepSync[1];

    // Read byte prepared well before the first data bit leaves on the link.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            readData <= 8'h00;
        end else if (readEvent) begin
            readData <= reqWiper ? wiper : settings[swcdSlot(reqPtr)];
        end
    end

    // A setting change starts a nonvolatile write when none is running.
    assign nvStart = cmdEvent && !nvBusy &&
                     ((cmdOp == OP_WRITE_SET) || (cmdOp == OP_XFR_TO_SET));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nvBusy  <= 1'b0;
            nvCount <= 24'h000000;
            nvSlot  <= 4'h0;
            nvData  <= 8'h00;
        end else if (nvStart) begin
            nvBusy  <= 1'b1;
            nvCount <= 24'(NV_CYCLES);
            nvSlot  <= (cmdOp == OP_XFR_TO_SET) ? swcdSlot({cmdPtr[3:2], 2'h0})
                                                : swcdSlot(cmdPtr);
            nvData  <= (cmdOp == OP_XFR_TO_SET) ? wiper : cmdData;
        end else if (nvBusy) begin
            nvCount <= nvCount - 24'h000001;
            if (nvCount == 24'h000001) begin
                nvBusy <= 1'b0;
            end
        end
    end

    // sixteen setting bytes
    // Nonvolatile array: no reset, committed at the end of the write cycle.
    always_ff @(posedge core_clk) begin
        if (nvBusy && (nvCount == 24'h000001)) begin
            settings[nvSlot] <= nvData;
        end
    end

    // Wiper register: power-up recall, direct write, transfer and stepping.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wiper       <= SWCD_WIPER_RESET;
            loadPending <= 1'b1;
        end else if (loadPending) begin
            wiper       <= settings[SWCD_DEFAULT_SLOT];
            loadPending <= 1'b0;
        end else if (cmdEvent && (cmdOp == OP_WRITE_WIPER)) begin
            wiper <= cmdData;
        end else if (cmdEvent && (cmdOp == OP_XFR_TO_WIPER)) begin
            wiper <= settings[swcdSlot({cmdPtr[3:2], 2'h0})];
        end else if (stepEvent) begin
            if (stepUp && (wiper != SWCD_WIPER_MAX)) begin
                wiper <= wiper + 8'h01;
            end else if (!stepUp && (wiper != SWCD_WIPER_MIN)) begin
                wiper <= wiper - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tapDelay <= 8'h00;
        end else if (cmdEvent && (cmdOp == OP_XFR_TO_WIPER)) begin
            tapDelay <= 8'(WIPER_RESPONSE_CYCLES);
        end else if (tapDelay != 8'h00) begin
            tapDelay <= tapDelay - 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tapSelect     <= swcdOneHot(SWCD_WIPER_RESET);
            wiperPosition <= SWCD_WIPER_RESET;
        end else if (tapDelay == 8'h00) begin
            tapSelect     <= swcdOneHot(wiper);
            wiperPosition <= wiper;
        end
    end

endmodule : swcd_serial_wiper_command_decoder

// file: swcd_pkg.sv
// Constants, opcodes, phase codes and decode helpers of the serial wiper command decoder.
// Assumes a single-potentiometer part with four banks of four setting registers.
package swcd_pkg;

    // Device type nibble of the address byte; the value is arbitrary.
    localparam logic [3:0] SWCD_ID_CODE      = 4'hA;
    localparam logic       SWCD_ADDR_FILL    = 1'h0;
    localparam logic [3:0] SWCD_LAST_BIT     = 4'h7;
    localparam logic [3:0] SWCD_ACK_SLOT     = 4'h8;
    localparam logic [7:0] SWCD_WIPER_MIN    = 8'h00;
    localparam logic [7:0] SWCD_WIPER_MAX    = 8'hFF;
    localparam logic [7:0] SWCD_WIPER_RESET  = 8'h00;
    localparam logic [3:0] SWCD_DEFAULT_SLOT = 4'h0;
    localparam int         SWCD_SETTING_NUM  = 16;

    // Clock and timing figures.
    localparam int CORE_CLK_PERIOD_NS        = 10;
    localparam int NV_WRITE_TIME_MS          = 10;
    localparam int NV_WRITE_CYCLES           = NV_WRITE_TIME_MS * 1000000 / CORE_CLK_PERIOD_NS;
    localparam int WIPER_RESPONSE_DELAY_NS   = 100;
    localparam int WIPER_RESPONSE_CYCLES     =
        (WIPER_RESPONSE_DELAY_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

    // Instruction opcodes (upper nibble of the instruction byte).
    typedef enum logic [3:0] {
        OP_STEP         = 4'h2,
        OP_READ_WIPER   = 4'h9,
        OP_WRITE_WIPER  = 4'hA,
        OP_READ_SET     = 4'hB,
        OP_WRITE_SET    = 4'hC,
        OP_XFR_TO_WIPER = 4'hD,
        OP_XFR_TO_SET   = 4'hE
    } swcd_op_t;

    // Byte phases of a frame on the link.
    typedef enum logic [2:0] {
        PH_ADDR   = 3'b000,
        PH_INSTR  = 3'b001,
        PH_DATA   = 3'b010,
        PH_STEP   = 3'b011,
        PH_IGNORE = 3'b100
    } swcd_phase_t;

    // Setting index {bank, register} from pointer {reg_select, bank_select}.
    function automatic logic [3:0] swcdSlot(input logic [3:0] ptr);
        return {ptr[1:0], ptr[3:2]};
    endfunction : swcdSlot

    // Legal opcode and pointer combinations of the instruction byte.
    function automatic logic swcdInstrValid(input logic [7:0] instr);
        logic ok;
        ok = 1'b0;
        case (instr[7:4])
            OP_READ_WIPER, OP_WRITE_WIPER, OP_STEP: ok = (instr[3:0] == 4'h0);
            OP_READ_SET, OP_WRITE_SET:              ok = 1'b1;
            OP_XFR_TO_WIPER, OP_XFR_TO_SET:         ok = (instr[1:0] == 2'h0);
            default:                                ok = 1'b0;
        endcase
        return ok;
    endfunction : swcdInstrValid

    // One tap switch on for one wiper position.
    function automatic logic [255:0] swcdOneHot(input logic [7:0] pos);
        logic [255:0] hot;
        hot = '0;
        hot[pos] = 1'b1;
        return hot;
    endfunction : swcdOneHot

endpackage : swcd_pkg

// file: swcd_assertions.sv
// Checker on the ports of the serial wiper command decoder.
// Assumes it is bound to the decoder with the same NV_CYCLES value.
`timescale 1ns/1ps
module swcd_checker
    import swcd_pkg::*;
#(
    parameter int NV_CYCLES = 50
) (
    // Clocks and reset.
    input wire logic         core_clk,
    input wire logic         rst,
    input wire logic         sclClk,
    // Link and strap pins.
    input wire logic         frameActive,
    input wire logic         sdaIn,
    input wire logic         sdaOut,
    input wire logic         sdaOeN,
    input wire logic [2:0]   addressPins,
    // Wiper and status.
    input wire logic [255:0] tapSelect,
    input wire logic [7:0]   wiperPosition,
    input wire logic         nvBusy
);
    int busyCount;
    // Counts the cycles of the running nonvolatile write.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busyCount <= 0;
        end else begin
            busyCount <= nvBusy ? busyCount + 1 : 0;
        end
    end
    tap_one_hot_a: assert property (@(posedge core_clk) disable iff (rst)
        tapSelect == (256'h1 << wiperPosition)) else $error("tap not one-hot of wiper");
    busy_max_a: assert property (@(posedge core_clk) disable iff (rst)
        nvBusy |-> busyCount <= NV_CYCLES + 1) else $error("write runs too long");
    busy_min_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(nvBusy) |-> busyCount >= NV_CYCLES - 1) else $error("write ends too early");
    busy_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(nvBusy) |=> nvBusy [*8]) else $error("write pulse too short");
    reset_state_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(rst) |-> wiperPosition == SWCD_WIPER_RESET && !nvBusy && sdaOeN)
        else $error("wrong state in reset");
    idle_wiper_a: assert property (@(posedge core_clk) disable iff (rst)
        nvBusy && $past(nvBusy) && !frameActive |-> $stable(wiperPosition))
        else $error("wiper moved during write");
    drive_low_a: assert property (@(posedge core_clk) disable iff (rst)
        !sdaOeN |-> !sdaOut) else $error("data pin driven high");
    stop_release_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(frameActive) |-> ##[0:3] sdaOeN) else $error("line held after stop");
    busy_nack_a: assert property (@(negedge sclClk) disable iff (!frameActive)
        nvBusy && $past(nvBusy, 3) |-> sdaOeN) else $error("ack given while busy");
endmodule : swcd_checker

bind swcd_serial_wiper_command_decoder swcd_checker #(.NV_CYCLES(NV_CYCLES)) i_chk (
    .core_clk(core_clk), .rst(rst), .sclClk(sclClk), .frameActive(frameActive),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addressPins(addressPins),
    .tapSelect(tapSelect), .wiperPosition(wiperPosition), .nvBusy(nvBusy)
);

// file: swcd_host_model.sv
// Behavioural two-wire bus master that frames bytes and steps for the decoder.
// Assumes the bench resolves the open-drain data line onto sdaLine.
`timescale 1ns/1ps
module swcd_host_model (
    // Link clock, frame and data drive.
    output logic      sclClk,
    output logic      frameActive,
    output logic      sdaMaster,
    // Resolved data line.
    input  wire logic sdaLine
);
    // Quarter of the 125 ns link clock period.
    localparam realtime Q = 31.25;
    // The link clock stands still and data is released between frames.
    initial begin
        sclClk = 1'b0;
        frameActive = 1'b0;
        sdaMaster = 1'b1;
    end
    // One clock pulse; data changes only while the clock is low.
    task automatic pulse(input logic bitVal, output logic seen);
        sdaMaster = bitVal;
        #Q sclClk = 1'b1;
        seen = sdaLine;
        #(2 * Q) sclClk = 1'b0;
        #Q;
    endtask : pulse
    // Opens a frame with the clock low.
    task automatic frameStart;
        #Q frameActive = 1'b1;
        #Q;
    endtask : frameStart
    // Releases the data line and closes the frame.
    task automatic frameStop;
        sdaMaster = 1'b1;
        #Q frameActive = 1'b0;
        #Q;
    endtask : frameStop
    task automatic putByte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(b[i], s);
        pulse(1'b1, s);
        acked = ~s;
    endtask : putByte
    task automatic getByte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
        pulse(1'b1, s);
    endtask : getByte
endmodule : swcd_host_model

// file: swcd_serial_wiper_command_decoder_tb.sv
// Self-checking bench of the serial wiper command decoder.
// Assumes a short nonvolatile write and the host model on the link.
`timescale 1ns/1ps
module swcd_serial_wiper_command_decoder_tb;
    import swcd_pkg::*;
    localparam int NV = 400;
    logic         core_clk, rst, sclClk, frameActive, sdaMaster;
    logic         sdaOut, sdaOeN, nvBusy, ackA, ackI, ackD, junk;
    logic [2:0]   addressPins;
    logic [7:0]   wiperPosition, rd;
    logic [255:0] tapSelect;
    logic [7:0]   badInstr [6] = '{8'h91, 8'hA4, 8'h21, 8'hD9, 8'hE2, 8'h50};
    int           miscompares, comparisons;
    wire          sdaLine;
    // Open-drain data line with pull-up.
    assign sdaLine = sdaMaster & sdaOeN;
    // Core clock of 100 MHz.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    swcd_serial_wiper_command_decoder #(.NV_CYCLES(NV)) i_dut (
        .core_clk(core_clk), .rst(rst), .sclClk(sclClk), .frameActive(frameActive),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addressPins(addressPins),
        .tapSelect(tapSelect), .wiperPosition(wiperPosition), .nvBusy(nvBusy)
    );
    swcd_host_model i_host (
        .sclClk(sclClk), .frameActive(frameActive), .sdaMaster(sdaMaster), .sdaLine(sdaLine)
    );
    // Prints the verdict and ends the run.
    task automatic tally_and_finish;
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Counts a comparison and reports a mismatch.
    task automatic compare(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : compare
    // Lets the core side settle after a frame.
    task automatic settle;
        repeat (30) @(posedge core_clk);
    endtask : settle
    // Sends the address byte from the strap pins and an instruction.
    task automatic startCmd(input logic [7:0] instr);
        i_host.frameStart();
        i_host.putByte({SWCD_ID_CODE, SWCD_ADDR_FILL, addressPins}, ackA);
        i_host.putByte(instr, ackI);
        compare("address ack", {7'h0, ackA}, 8'h01);
    endtask : startCmd
    // Three-byte write command.
    task automatic wr(input logic [7:0] instr, input logic [7:0] data);
        startCmd(instr);
        i_host.putByte(data, ackD);
        i_host.frameStop();
        compare("write acks", {6'h0, ackI, ackD}, 8'h03);
    endtask : wr
    // Three-byte read command.
    task automatic rdCmd(input logic [7:0] instr, input logic [7:0] exp);
        startCmd(instr);
        i_host.getByte(rd);
        i_host.frameStop();
        compare("read ack", {7'h0, ackI}, 8'h01);
        compare("read data", rd, exp);
    endtask : rdCmd
    // Two-byte transfer command.
    task automatic transfer_op(input logic [7:0] instr);
        startCmd(instr);
        i_host.frameStop();
        compare("transfer ack", {7'h0, ackI}, 8'h01);
    endtask : transfer_op
    task automatic waitNv;
        i_host.frameStart();
        i_host.putByte({SWCD_ID_CODE, SWCD_ADDR_FILL, addressPins}, ackA);
        i_host.frameStop();
        compare("poll while busy", {7'h0, ackA}, 8'h00);
        for (int n = 0; n < 1000 && nvBusy !== 1'b0; n++) @(posedge core_clk);
        if (nvBusy !== 1'b0) begin
            miscompares++;
            tally_and_finish();
        end
        settle();
    endtask : waitNv
    task automatic stepRun(input logic [7:0] from, input logic [4:0] dirs, input logic [7:0] exp);
        wr(8'hA0, from);
        settle();
        compare("written wiper", wiperPosition, from);
        startCmd(8'h20);
        compare("step ack", {7'h0, ackI}, 8'h01);
        for (int k = 4; k >= 0; k--) i_host.pulse(dirs[k], junk);
        i_host.frameStop();
        settle();
        compare("stepped wiper", wiperPosition, exp);
    endtask : stepRun
    // Main sequence.
    initial begin
        rst = 1'b1;
        addressPins = 3'h5;
        miscompares = 0;
        comparisons = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        for (int p = 0; p < 16; p += 5) begin
            wr(8'hC0 | 8'(p), {4'(p), ~4'(p)});
            waitNv();
            rdCmd(8'hB0 | 8'(p), {4'(p), ~4'(p)});
        end
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        compare("recalled wiper", wiperPosition, 8'h0F);
        compare("tap of wiper", {7'h0, tapSelect[15]}, 8'h01);
        stepRun(8'hFE, 5'b11000, 8'hFC);
        stepRun(8'h01, 5'b00010, 8'h00);
        stepRun(8'h80, 5'b10111, 8'h83);
        rdCmd(8'h90, 8'h83);
        wr(8'hA0, 8'h6B);
        transfer_op(8'hE8);
        waitNv();
        rdCmd(8'hB8, 8'h6B);
        wr(8'hA0, 8'h00);
        transfer_op(8'hD8);
        settle();
        compare("transferred wiper", wiperPosition, 8'h6B);
        foreach (badInstr[k]) begin
            startCmd(badInstr[k]);
            i_host.frameStop();
            compare("refused instruction", {7'h0, ackI}, 8'h00);
        end
        settle();
        compare("wiper kept", wiperPosition, 8'h6B);
        addressPins <= 3'h2;
        settle();
        i_host.frameStart();
        i_host.putByte({SWCD_ID_CODE, SWCD_ADDR_FILL, 3'h5}, ackA);
        i_host.frameStop();
        compare("old address", {7'h0, ackA}, 8'h00);
        rdCmd(8'h90, 8'h6B);
        tally_and_finish();
    end
    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : swcd_serial_wiper_command_decoder_tb
